// ==== clock_domain_control.v ====
`include "clock_domain_control_defs.vh"

// Summary of operation
// - Slow internal oscillator output is clock source number 4.
// - Fast internal oscillator output is clock source number 5.
// - Fast internal oscillator feeds the main oscillator failure detector.
// - Frequency modulation on the loop output is optionally enabled.
// - Loop slips are flagged; optional whole-device reset on slip.
// - Domain disable bit 1 stops the system bus domain.
// - Processor core runs with bus clock, in phase, outside self-test.
// - Domain disable bit 0 stops the processor core and checker core clocks.
// - During self-test the core clock divides by 1 to 8.
// - Checker core clock equals core clock, lagging two cycles.
// - Checker clock gated and divided together with core clock.
// - Both peripheral clocks derive from bus clock by 1, 2 or 16.
// - Domain disable bit 2 stops the primary peripheral clock.
// - Domain disable bit 9 gates primary peripheral clock to encoder.
// - Domain disable bit 3 stops the secondary peripheral clock.
// - Async peripheral clock defaults to primary peripheral, selectable.
// - Domain disable bit 4 stops the async peripheral domain.
// - Domain disable bit 6 stops the timer clock domain.
// - Each source has a disable bit at its source number.
// - Oscillator failure sets status bit 0 and moves to limp clock.
module clock_domain_control (
    input wire mclk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire main_oscillator_input,
    input wire loop_clock_input,
    input wire ext_clock_input,
    input wire slow_internal_source,
    input wire fast_internal_source,
    input wire osc_fail_in,
    input wire loop_slip_in,
    input wire selftest_active,
    output reg bus_clock_en,
    output reg processor_core_clock_en,
    output reg checker_core_clock_en,
    output reg primary_peripheral_clock_en,
    output reg encoder_clock_en,
    output reg secondary_peripheral_clock_en,
    output reg async_peripheral_clock_en,
    output reg os_timer_clock_en,
    output reg osc_detect_ref_en,
    output reg [7:0] source_enable,
    output reg loop_modulation_en,
    output reg device_reset_req
);

    reg [7:0] src_dis_q;
    reg [9:0] dom_dis_q;
    reg [2:0] stc_div_q;
    reg [2:0] main_sel_q;
    reg [3:0] async_sel_q;
    reg [3:0] timer_sel_q;
    reg [1:0] timer_div_q;
    reg [1:0] p1_ratio_q;
    reg [1:0] p2_ratio_q;
    reg [1:0] loop_ctl_q;
    reg osc_fail_q;
    reg slip_seen_q;
    reg [7:0] s1_q;
    reg [7:0] s2_q;
    reg [7:0] s3_q;
    reg [1:0] fail_sync_q;
    reg [1:0] slip_sync_q;
    reg slip_prev_q;
    reg [2:0] prime_q;
    reg [2:0] stc_cnt_q;
    reg [3:0] pcnt_q;
    reg [2:0] tcnt_q;
    reg [1:0] lag_q;
    wire [7:0] src_raw;
    wire [7:0] src_tick;
    wire [2:0] main_eff;
    wire bus_tick;
    wire core_tick;
    wire p1_tick;
    wire p2_tick;
    wire async_tick;
    wire timer_src_tick;
    wire timer_tick;
    wire slip_pulse;
    wire acc;
    wire wr;
    reg [31:0] rd_d;
    reg hit_d;

    // Source number is the bit position; reserved slots stay low
    assign src_raw = {2'h0, fast_internal_source, slow_internal_source,
                      ext_clock_input, 1'b0, loop_clock_input,
                      main_oscillator_input};

    // Two-stage synchronisers per source, third stage only for edges
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
            fail_sync_q <= 2'h0;
            slip_sync_q <= 2'h0;
            slip_prev_q <= 1'b0;
            prime_q <= 3'h0;
        end
        else
        begin
            // Third stage holds a reset value, not a pin sample, at first
            prime_q <= {prime_q[1:0], 1'b1};
            s1_q <= src_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            fail_sync_q <= {fail_sync_q[0], osc_fail_in};
            slip_sync_q <= {slip_sync_q[0], loop_slip_in};
            slip_prev_q <= slip_sync_q[1];
        end
    end

    // Rising edge of each source, dropped while that source is disabled
    // No edges until the third stage is primed, else a false edge follows reset
    assign src_tick = s2_q & ~s3_q & ~src_dis_q & {8{prime_q[2]}};
    assign slip_pulse = slip_sync_q[1] & ~slip_prev_q;

    // Limp mode: a failed oscillator is replaced by the fast internal one
    assign main_eff = (osc_fail_q && main_sel_q == `SRC_MAIN_OSC) ?
                      `SRC_FAST_INTERNAL : main_sel_q;
    assign bus_tick = src_tick[main_eff];

    // Core tick equals bus tick unless self-test divides it
    assign core_tick = bus_tick &
                       (!selftest_active || stc_cnt_q == stc_div_q);

    // Peripheral ratios share one counter so the two stay aligned
    assign p1_tick = bus_tick & (p1_ratio_q == `RATIO_DIV1 ||
                     (p1_ratio_q == `RATIO_DIV2 && pcnt_q[0]) ||
                     (p1_ratio_q[1] && pcnt_q == 4'hF));
    assign p2_tick = bus_tick & (p2_ratio_q == `RATIO_DIV1 ||
                     (p2_ratio_q == `RATIO_DIV2 && pcnt_q[0]) ||
                     (p2_ratio_q[1] && pcnt_q == 4'hF));

    // Select codes 8 and above mean the primary peripheral clock
    assign async_tick = async_sel_q[3] ? p1_tick :
        ((osc_fail_q && async_sel_q[2:0] == `SRC_MAIN_OSC) ?
         src_tick[`SRC_FAST_INTERNAL] : src_tick[async_sel_q[2:0]]);
    assign timer_src_tick = timer_sel_q[3] ? p1_tick :
        ((osc_fail_q && timer_sel_q[2:0] == `SRC_MAIN_OSC) ?
         src_tick[`SRC_FAST_INTERNAL] : src_tick[timer_sel_q[2:0]]);

    // Timer divider by 1, 2, 4 or 8 keeps foreign sources slow enough
    assign timer_tick = timer_src_tick &
        ((tcnt_q & ((3'h1 << timer_div_q) - 3'h1)) ==
         ((3'h1 << timer_div_q) - 3'h1));

    // Divider counters run on their own source ticks
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stc_cnt_q <= 3'h0;
            pcnt_q <= 4'h0;
            tcnt_q <= 3'h0;
        end
        else
        begin
            if (!selftest_active)
                stc_cnt_q <= 3'h0;
            else if (bus_tick)
                stc_cnt_q <= (stc_cnt_q == stc_div_q) ? 3'h0 :
                             stc_cnt_q + 3'h1;
            if (bus_tick)
                pcnt_q <= pcnt_q + 4'h1;
            if (timer_src_tick)
                tcnt_q <= tcnt_q + 3'h1;
        end
    end

    // Registered domain enables; gating by the disable bits
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_clock_en <= 1'b0;
            processor_core_clock_en <= 1'b0;
            lag_q <= 2'h0;
            checker_core_clock_en <= 1'b0;
            primary_peripheral_clock_en <= 1'b0;
            encoder_clock_en <= 1'b0;
            secondary_peripheral_clock_en <= 1'b0;
            async_peripheral_clock_en <= 1'b0;
            os_timer_clock_en <= 1'b0;
            osc_detect_ref_en <= 1'b0;
        end
        else
        begin
            bus_clock_en <= bus_tick & ~dom_dis_q[`DIS_BUS];
            processor_core_clock_en <= core_tick &
                                       ~dom_dis_q[`DIS_CORE];
            // Lag taken from the gated core tick, so gating follows
            lag_q <= {lag_q[0], core_tick & ~dom_dis_q[`DIS_CORE]};
            checker_core_clock_en <= lag_q[`CHECKER_LAG - 1];
            primary_peripheral_clock_en <= p1_tick &
                                           ~dom_dis_q[`DIS_PERIPH];
            encoder_clock_en <= p1_tick & ~dom_dis_q[`DIS_PERIPH] &
                                ~dom_dis_q[`DIS_ENCODER];
            secondary_peripheral_clock_en <= p2_tick &
                                             ~dom_dis_q[`DIS_PERIPH2];
            async_peripheral_clock_en <= async_tick &
                                         ~dom_dis_q[`DIS_ASYNC];
            os_timer_clock_en <= timer_tick & ~dom_dis_q[`DIS_TIMER];
            // Reference runs even if software disables the source
            osc_detect_ref_en <= s2_q[`SRC_FAST_INTERNAL] &
                                 ~s3_q[`SRC_FAST_INTERNAL] &
                                 prime_q[2];
        end
    end

    // APB: zero-wait slave, answer prepared during the setup cycle
    assign acc = psel & penable & pready;
    assign wr = acc & pwrite & ~pslverr;

    // Read mux and address decode
    always @*
    begin
        rd_d = 32'h00000000;
        hit_d = 1'b1;
        case (paddr)
            `ADDR_SOURCE_DISABLE:
                rd_d[7:0] = src_dis_q;
            `ADDR_DOMAIN_DISABLE:
                rd_d[9:0] = dom_dis_q;
            `ADDR_SELFTEST_CLOCK_DIVIDER:
                rd_d[2:0] = stc_div_q;
            `ADDR_MAIN_DOMAIN_SOURCE_SELECT:
                rd_d[2:0] = main_sel_q;
            `ADDR_ASYNC_DOMAIN_SOURCE_SELECT:
                rd_d[3:0] = async_sel_q;
            `ADDR_TIMER_DOMAIN_SOURCE_SELECT:
            begin
                rd_d[3:0] = timer_sel_q;
                rd_d[9:8] = timer_div_q;
            end
            `ADDR_PERIPHERAL_DIVIDER:
            begin
                rd_d[1:0] = p1_ratio_q;
                rd_d[9:8] = p2_ratio_q;
            end
            `ADDR_LOOP_CONTROL:
                rd_d[1:0] = loop_ctl_q;
            `ADDR_GLOBAL_STATUS_REGISTER:
            begin
                rd_d[`STAT_OSC_FAIL_BIT] = osc_fail_q;
                rd_d[`STAT_SLIP_BIT] = slip_seen_q;
            end
            default:
                hit_d = 1'b0;
        endcase
    end

    // Bus answer flops
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_d;
            prdata <= (psel & ~penable & ~pwrite) ? rd_d : 32'h00000000;
        end
    end

    // Configuration registers
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            src_dis_q <= `RST_SOURCE_DISABLE;
            dom_dis_q <= `RST_DOMAIN_DISABLE;
            stc_div_q <= `RST_SELFTEST_DIVIDE;
            main_sel_q <= `RST_MAIN_SOURCE;
            async_sel_q <= `RST_ASYNC_SOURCE;
            timer_sel_q <= `RST_TIMER_SOURCE;
            timer_div_q <= `RST_TIMER_DIVIDE;
            p1_ratio_q <= `RST_PERIPHERAL_RATIO;
            p2_ratio_q <= `RST_PERIPHERAL_RATIO;
            loop_ctl_q <= `RST_LOOP_CONTROL;
        end
        else if (wr)
        begin
            case (paddr)
                `ADDR_SOURCE_DISABLE:
                    src_dis_q <= pwdata[7:0];
                `ADDR_DOMAIN_DISABLE:
                    dom_dis_q <= pwdata[9:0];
                `ADDR_SELFTEST_CLOCK_DIVIDER:
                    stc_div_q <= pwdata[`STC_DIV_LSB +: 3];
                `ADDR_MAIN_DOMAIN_SOURCE_SELECT:
                    main_sel_q <= pwdata[2:0];
                `ADDR_ASYNC_DOMAIN_SOURCE_SELECT:
                    async_sel_q <= pwdata[3:0];
                `ADDR_TIMER_DOMAIN_SOURCE_SELECT:
                begin
                    timer_sel_q <= pwdata[3:0];
                    timer_div_q <= pwdata[`TIMER_DIV_LSB +: 2];
                end
                `ADDR_PERIPHERAL_DIVIDER:
                begin
                    p1_ratio_q <= pwdata[1:0];
                    p2_ratio_q <= pwdata[`PERIPH2_RATIO_LSB +: 2];
                end
                `ADDR_LOOP_CONTROL:
                    loop_ctl_q <= pwdata[1:0];
                default:
                    loop_ctl_q <= loop_ctl_q;
            endcase
        end
    end

    // Sticky status; a new event beats a write-one-to-clear
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_fail_q <= 1'b0;
            slip_seen_q <= 1'b0;
        end
        else
        begin
            if (fail_sync_q[1])
                osc_fail_q <= 1'b1;
            else if (wr && paddr == `ADDR_GLOBAL_STATUS_REGISTER &&
                     pwdata[`STAT_OSC_FAIL_BIT])
                osc_fail_q <= 1'b0;
            if (slip_pulse)
                slip_seen_q <= 1'b1;
            else if (wr && paddr == `ADDR_GLOBAL_STATUS_REGISTER &&
                     pwdata[`STAT_SLIP_BIT])
                slip_seen_q <= 1'b0;
        end
    end

    // Loop side outputs and source enables
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            source_enable <= ~`RST_SOURCE_DISABLE;
            loop_modulation_en <= 1'b0;
            device_reset_req <= 1'b0;
        end
        else
        begin
            source_enable <= ~src_dis_q;
            loop_modulation_en <= loop_ctl_q[`LOOP_FM_BIT];
            device_reset_req <= slip_pulse &
                                loop_ctl_q[`LOOP_SLIP_RESET_BIT];
        end
    end

endmodule

// ==== clock_domain_control_checker.sv ====
module clock_domain_control_checker (
    input wire mclk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire fast_internal_source,
    input wire loop_slip_in,
    input wire processor_core_clock_en,
    input wire checker_core_clock_en,
    input wire primary_peripheral_clock_en,
    input wire encoder_clock_en,
    input wire osc_detect_ref_en,
    input wire device_reset_req
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // Bus phases as seen by the slave
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    property p_ready_first;
        s_setup ##1 s_access |-> pready;
    endproperty
    a_ready_first: assert property (p_ready_first)
        else $error("pready missing in first access cycle");
    property p_ready_single;
        pready |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("pready held longer than one cycle");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside an answer");
    // Checker pulses mirror core pulses two cycles later, both ways
    property p_checker_lag;
        checker_core_clock_en == $past(processor_core_clock_en, 2);
    endproperty
    a_checker_lag: assert property (p_checker_lag)
        else $error("checker pulse not two cycles after core pulse");
    property p_encoder_gate;
        encoder_clock_en |-> primary_peripheral_clock_en;
    endproperty
    a_encoder_gate: assert property (p_encoder_gate)
        else $error("encoder pulse without peripheral pulse");
    property p_slip_reset;
        device_reset_req |-> ($past(loop_slip_in, 3) && !$past(loop_slip_in, 4))
            ##1 !device_reset_req;
    endproperty
    a_slip_reset: assert property (p_slip_reset)
        else $error("reset request not a single pulse after slip");
    property p_ref_tick;
        osc_detect_ref_en |-> $past(fast_internal_source, 3)
            && !$past(fast_internal_source, 4) && !$past(osc_detect_ref_en);
    endproperty
    a_ref_tick: assert property (p_ref_tick)
        else $error("detector reference pulse without source edge");
endmodule

bind clock_domain_control clock_domain_control_checker i_chk (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_internal_source(fast_internal_source),
    .loop_slip_in(loop_slip_in),
    .processor_core_clock_en(processor_core_clock_en),
    .checker_core_clock_en(checker_core_clock_en),
    .primary_peripheral_clock_en(primary_peripheral_clock_en),
    .encoder_clock_en(encoder_clock_en),
    .osc_detect_ref_en(osc_detect_ref_en),
    .device_reset_req(device_reset_req));

// ==== clock_domain_control_defs.vh ====
`ifndef CLOCK_DOMAIN_CONTROL_DEFS_VH
`define CLOCK_DOMAIN_CONTROL_DEFS_VH

// Register byte addresses (APB, one 32-bit word each)
`define ADDR_SOURCE_DISABLE 32'hFFFFE100
`define ADDR_DOMAIN_DISABLE 32'hFFFFE104
`define ADDR_SELFTEST_CLOCK_DIVIDER 32'hFFFFE108
`define ADDR_MAIN_DOMAIN_SOURCE_SELECT 32'hFFFFE10C
`define ADDR_ASYNC_DOMAIN_SOURCE_SELECT 32'hFFFFE110
`define ADDR_TIMER_DOMAIN_SOURCE_SELECT 32'hFFFFE114
`define ADDR_PERIPHERAL_DIVIDER 32'hFFFFE118
`define ADDR_LOOP_CONTROL 32'hFFFFE11C
`define ADDR_GLOBAL_STATUS_REGISTER 32'hFFFFE120

// Reset values
`define RST_SOURCE_DISABLE 8'hCE
`define RST_DOMAIN_DISABLE 10'h000
`define RST_SELFTEST_DIVIDE 3'h0
`define RST_MAIN_SOURCE 3'h0
`define RST_ASYNC_SOURCE 4'h8
`define RST_TIMER_SOURCE 4'h8
`define RST_TIMER_DIVIDE 2'h0
`define RST_PERIPHERAL_RATIO 2'h0
`define RST_LOOP_CONTROL 2'h0

// Clock source numbers
`define SRC_MAIN_OSC 3'h0
`define SRC_LOOP 3'h1
`define SRC_EXT 3'h3
`define SRC_SLOW_INTERNAL 3'h4
`define SRC_FAST_INTERNAL 3'h5

// Domain disable bit positions
`define DIS_CORE 0
`define DIS_BUS 1
`define DIS_PERIPH 2
`define DIS_PERIPH2 3
`define DIS_ASYNC 4
`define DIS_TIMER 6
`define DIS_ENCODER 9

// Field positions
`define STC_DIV_LSB 0
`define TIMER_DIV_LSB 8
`define PERIPH2_RATIO_LSB 8
`define LOOP_FM_BIT 0
`define LOOP_SLIP_RESET_BIT 1
`define STAT_OSC_FAIL_BIT 0
`define STAT_SLIP_BIT 1

// Peripheral ratio codes: 0 /1, 1 /2, 2 or 3 /16
`define RATIO_DIV1 2'h0
`define RATIO_DIV2 2'h1

// Checker core lag in clock cycles
`define CHECKER_LAG 2

`endif

// ==== clock_domain_control_tb.sv ====
`include "clock_domain_control_defs.vh"
module clock_domain_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, nrst, psel, penable, pwrite, rerr;
    logic [31:0] paddr, pwdata, rd;
    logic main_in, loop_in, ext_in, slow_in, fast_in, fail_in, slip_in, st_in;
    wire [31:0] prdata;
    wire pready, pslverr, loop_modulation_en, device_reset_req;
    wire [8:0] ens;
    wire [7:0] source_enable;
    int fails, cmp_count, cyc;
    int cnt [0:8];

    clock_domain_control i_clock_domain_control (
        .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .main_oscillator_input(main_in), .loop_clock_input(loop_in),
        .ext_clock_input(ext_in), .slow_internal_source(slow_in),
        .fast_internal_source(fast_in), .osc_fail_in(fail_in),
        .loop_slip_in(slip_in), .selftest_active(st_in),
        .bus_clock_en(ens[0]), .processor_core_clock_en(ens[1]),
        .checker_core_clock_en(ens[2]),
        .primary_peripheral_clock_en(ens[3]), .encoder_clock_en(ens[4]),
        .secondary_peripheral_clock_en(ens[5]),
        .async_peripheral_clock_en(ens[6]), .os_timer_clock_en(ens[7]),
        .osc_detect_ref_en(ens[8]), .source_enable(source_enable),
        .loop_modulation_en(loop_modulation_en),
        .device_reset_req(device_reset_req));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Source pins with periods 16, 4, 32, 128 and 8 cycles; hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        main_in <= cyc[3];
        loop_in <= cyc[1];
        ext_in <= cyc[4];
        slow_in <= cyc[6];
        fast_in <= cyc[2];
        if (cyc == 12000)
        begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer; only the bench timeout bounds the wait for pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Settle after a change, then count pulses of every domain output
    task automatic count(input int n);
        repeat (24) @(posedge mclk);
        for (int i = 0; i < 9; i++)
            cnt[i] = 0;
        repeat (n)
        begin
            @(posedge mclk);
            for (int i = 0; i < 9; i++)
                cnt[i] += ens[i];
        end
    endtask

    task automatic t_regs();
        logic [31:0] rv [0:8] = '{32'hCE, 32'h0, 32'h0, 32'h0, 32'h8,
            32'h8, 32'h0, 32'h0, 32'h0};
        cmp({24'h0, source_enable}, 32'h31);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, `ADDR_SOURCE_DISABLE + 4 * i, 32'h0);
            cmp(rd, (i < 9) ? rv[i] : 32'h0);
            cmp({31'h0, rerr}, (i == 9) ? 32'h1 : 32'h0);
        end
        apb(1'b1, 32'hFFFFE124, 32'hFFFFFFFF);
        cmp({31'h0, rerr}, 32'h1);
        apb(1'b1, `ADDR_SELFTEST_CLOCK_DIVIDER, 32'h5);
        apb(1'b0, `ADDR_SELFTEST_CLOCK_DIVIDER, 32'h0);
        cmp(rd, 32'h5);
        $display("done t_regs");
    endtask

    task automatic t_default();
        count(160);
        for (int i = 0; i < 8; i++)
            cmp(cnt[i], 10);
        cmp(cnt[8], 20);
        $display("done t_default");
    endtask

    task automatic t_sources();
        int src [0:4] = '{0, 1, 3, 4, 5};
        int per [0:4] = '{16, 4, 32, 128, 8};
        apb(1'b1, `ADDR_SOURCE_DISABLE, 32'h0);
        repeat (2) @(posedge mclk);
        cmp({24'h0, source_enable}, 32'hFF);
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, `ADDR_MAIN_DOMAIN_SOURCE_SELECT, src[i]);
            count(128);
            cmp(cnt[0], 128 / per[i]);
        end
        apb(1'b1, `ADDR_SOURCE_DISABLE, 32'h22);
        apb(1'b1, `ADDR_MAIN_DOMAIN_SOURCE_SELECT, 32'h1);
        count(128);
        cmp(cnt[0], 0);
        cmp(cnt[8], 16);
        apb(1'b1, `ADDR_SOURCE_DISABLE, 32'h0);
        apb(1'b1, `ADDR_MAIN_DOMAIN_SOURCE_SELECT, 32'h0);
        apb(1'b1, `ADDR_ASYNC_DOMAIN_SOURCE_SELECT, 32'h5);
        apb(1'b1, `ADDR_TIMER_DOMAIN_SOURCE_SELECT, 32'h305);
        count(128);
        cmp(cnt[6], 16);
        cmp(cnt[7], 2);
        apb(1'b1, `ADDR_ASYNC_DOMAIN_SOURCE_SELECT, 32'h8);
        apb(1'b1, `ADDR_TIMER_DOMAIN_SOURCE_SELECT, 32'h8);
        $display("done t_sources");
    endtask

    task automatic t_ratios();
        int e;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `ADDR_PERIPHERAL_DIVIDER, i * 257);
            e = (i == 0) ? 16 : (i == 1) ? 8 : 1;
            count(256);
            cmp(cnt[3], e);
            cmp(cnt[5], e);
            cmp(cnt[6], e);
            cmp(cnt[4], e);
        end
        apb(1'b1, `ADDR_PERIPHERAL_DIVIDER, 32'h0);
        $display("done t_ratios");
    endtask

    task automatic t_disable();
        int bits [0:6] = '{0, 1, 2, 3, 4, 6, 9};
        int idx [0:6] = '{1, 0, 3, 5, 6, 7, 4};
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, `ADDR_DOMAIN_DISABLE, 1 << bits[i]);
            count(160);
            cmp(cnt[idx[i]], 0);
            cmp(cnt[(bits[i] == 1) ? 1 : 0], 10);
            if (bits[i] == 0)
                cmp(cnt[2], 0);
            if (bits[i] == 9)
                cmp(cnt[3], 10);
        end
        apb(1'b1, `ADDR_DOMAIN_DISABLE, 32'h0);
        $display("done t_disable");
    endtask

    task automatic t_selftest();
        int k [0:3] = '{1, 2, 4, 8};
        @(posedge mclk);
        st_in <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `ADDR_SELFTEST_CLOCK_DIVIDER, k[i] - 1);
            count(256);
            cmp(cnt[1], 16 / k[i]);
            cmp(cnt[2], 16 / k[i]);
            cmp(cnt[0], 16);
        end
        @(posedge mclk);
        st_in <= 1'b0;
        count(256);
        cmp(cnt[1], 16);
        $display("done t_selftest");
    endtask

    task automatic slip(input int e);
        int n = 0;
        @(posedge mclk);
        slip_in <= 1'b1;
        repeat (10)
        begin
            @(posedge mclk);
            n += device_reset_req;
        end
        slip_in <= 1'b0;
        repeat (6) @(posedge mclk);
        cmp(n, e);
    endtask

    task automatic t_limp_loop();
        @(posedge mclk);
        fail_in <= 1'b1;
        count(128);
        cmp(cnt[0], 16);
        apb(1'b0, `ADDR_GLOBAL_STATUS_REGISTER, 32'h0);
        cmp(rd, 32'h1);
        @(posedge mclk);
        fail_in <= 1'b0;
        repeat (8) @(posedge mclk);
        apb(1'b1, `ADDR_GLOBAL_STATUS_REGISTER, 32'h1);
        count(128);
        cmp(cnt[0], 8);
        apb(1'b1, `ADDR_LOOP_CONTROL, 32'h1);
        repeat (2) @(posedge mclk);
        cmp({31'h0, loop_modulation_en}, 32'h1);
        apb(1'b1, `ADDR_LOOP_CONTROL, 32'h2);
        slip(1);
        cmp({31'h0, loop_modulation_en}, 32'h0);
        apb(1'b0, `ADDR_GLOBAL_STATUS_REGISTER, 32'h0);
        cmp(rd, 32'h2);
        apb(1'b1, `ADDR_LOOP_CONTROL, 32'h0);
        slip(0);
        $display("done t_limp_loop");
    endtask

    initial
    begin
        fails = 0;
        cmp_count = 0;
        cyc = 0;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {main_in, loop_in, ext_in, slow_in, fast_in} = '0;
        {fail_in, slip_in, st_in} = '0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        t_regs();
        t_default();
        t_sources();
        t_ratios();
        t_disable();
        t_selftest();
        t_limp_loop();
        conclude();
    end
endmodule
